// File: hw/acpd_pkg.sv
// Constants and types of the converter control block.
// Assumes one conversion clock of 20 MHz and a synchronous low reset.
package acpd_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned CLK_MIN_HZ       = 1_000_000;
  localparam int unsigned CLK_MAX_HZ       = 80_000_000;
  localparam int unsigned RECOVERY_NS      = 300;
  localparam int unsigned RECOVERY_CYCLES  =
    (RECOVERY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned LATENCY_CYCLES   = 6;

  // ****************************************************************
  // Data format and reset values
  // ****************************************************************
  localparam int unsigned DATA_W           = 12;
  localparam int unsigned FIFO_DEPTH       = 16;
  localparam logic [11:0] MID_SCALE        = 12'h800;
  localparam logic [11:0] RESET_WORD       = 12'h000;
  localparam logic [11:0] UNDEF_WORD       = 12'hFFF;

  // Power state of the converter core
  typedef enum logic [1:0] {
    ACPD_RUN,
    ACPD_SLEEP,
    ACPD_RECOVER
  } acpd_state_t;

endpackage

// File: hw/acpd_stream_if.sv
// Stream carrier between the converter core and its output buffer.
// Assumes both ends run on the same conversion clock.
`timescale 1ns/10ps
interface acpd_stream_if #(
  parameter int unsigned WIDTH = 12
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// File: hw/acpd_fifo.sv
// Word buffer with valid and ready on both sides.
// Assumes a single clock and a synchronous low reset.
`timescale 1ns/10ps
module acpd_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic flush,
  acpd_stream_if.sink   wr,
  acpd_stream_if.source rd
);
  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("acpd_fifo depth must be a power of two");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [WIDTH-1:0] out_word;
  logic             out_valid;
  logic             empty;
  logic             full;
  logic             pop;

  // ****************************************************************
  // Flags and handshakes
  // ****************************************************************
  assign empty    = (wr_ptr == rd_ptr);
  assign full     = (wr_ptr[AW] != rd_ptr[AW]) &&
                    (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign wr.ready = !full;
  assign pop      = !empty && (!out_valid || rd.ready);
  assign rd.valid = out_valid;
  assign rd.data  = out_word;

  // ****************************************************************
  // Storage
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (wr.valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || flush) begin
      wr_ptr <= '0;
    end else if (wr.valid && !full) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || flush) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Registered read word
  always_ff @(posedge clk) begin
    if (!reset_n || flush) begin
      out_valid <= 1'b0;
      out_word  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_word  <= mem[rd_ptr[AW-1:0]];
    end else if (rd.ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule // acpd_fifo

// File: hw/acpd_core.sv
// Digital control of a pipelined 12-bit sampling converter.
// Assumes clk is the partner's conversion clock and the sample code
// arrives already digitised on sample_in, synchronous to clk.
`timescale 1ns/10ps
module acpd_core #(
  parameter int unsigned DATA_W     = acpd_pkg::DATA_W,
  parameter int unsigned LATENCY    = acpd_pkg::LATENCY_CYCLES,
  parameter int unsigned FIFO_DEPTH = acpd_pkg::FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [DATA_W-1:0] sample_in,
  input  wire logic              output_enable_n,
  input  wire logic              sleep_request,
  input  wire logic              drain_ready,
  output logic      [DATA_W-1:0] data_out,
  output logic      [DATA_W-1:0] data_oe,
  output logic                   data_valid,
  output logic                   word_strobe,
  output logic                   sleeping,
  output logic                   recovering,
  output logic                   fifo_overflow
);
  initial begin
    if (DATA_W != acpd_pkg::DATA_W || LATENCY < 4 || FIFO_DEPTH < 2) begin
      $error("acpd_core parameters out of range");
    end
  end

  localparam int unsigned REC_W = $clog2(acpd_pkg::RECOVERY_CYCLES + 1);
  localparam logic [REC_W-1:0] REC_LOAD =
    REC_W'(acpd_pkg::RECOVERY_CYCLES);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic oe_n_meta;
  logic oe_n_sync;
  logic sleep_meta;
  logic sleep_sync;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      oe_n_meta  <= 1'b1;
      oe_n_sync  <= 1'b1;
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
    end else begin
      oe_n_meta  <= output_enable_n;
      oe_n_sync  <= oe_n_meta;
      sleep_meta <= sleep_request;
      sleep_sync <= sleep_meta;
    end
  end

  // ****************************************************************
  // Power state
  // ****************************************************************
  acpd_pkg::acpd_state_t state;
  acpd_pkg::acpd_state_t next_state;
  logic [REC_W-1:0]      rec_count;

  always_comb begin
    next_state = state;
    case (state)
      acpd_pkg::ACPD_RUN: begin
        if (sleep_sync) begin
          next_state = acpd_pkg::ACPD_SLEEP;
        end
      end
      acpd_pkg::ACPD_SLEEP: begin
        if (!sleep_sync) begin
          next_state = acpd_pkg::ACPD_RECOVER;
        end
      end
      acpd_pkg::ACPD_RECOVER: begin
        if (sleep_sync) begin
          next_state = acpd_pkg::ACPD_SLEEP;
        end else if (rec_count <= REC_W'(1)) begin
          next_state = acpd_pkg::ACPD_RUN; // Exactly the recovery count
        end
      end
      default: next_state = acpd_pkg::ACPD_SLEEP;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= acpd_pkg::ACPD_SLEEP;
    end else begin
      state <= next_state;
    end
  end

  // Recharge interval after leaving sleep
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rec_count <= REC_LOAD;
    end else if (state != acpd_pkg::ACPD_RECOVER) begin
      rec_count <= REC_LOAD;
    end else if (rec_count != '0) begin
      rec_count <= rec_count - 1'b1;
    end
  end

  assign sleeping   = (state == acpd_pkg::ACPD_SLEEP);
  assign recovering = (state == acpd_pkg::ACPD_RECOVER);

  // ****************************************************************
  // Conversion pipeline
  // ****************************************************************
  // Buffer read register and pin register take the last two cycles
  logic [DATA_W-1:0] pipe_word  [LATENCY-2];
  logic [LATENCY-3:0] pipe_good;
  logic              active;

  assign active = (state == acpd_pkg::ACPD_RUN);

  // Words run every cycle whatever the enable level
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < LATENCY - 2; i++) begin
        pipe_word[i] <= acpd_pkg::RESET_WORD;
      end
    end else begin
      pipe_word[0] <= sample_in;
      for (int i = 1; i < LATENCY - 2; i++) begin
        pipe_word[i] <= pipe_word[i-1];
      end
    end
  end

  // Sleep clears every validity mark in flight
  always_ff @(posedge clk) begin
    if (!reset_n || !active) begin
      pipe_good <= '0;
    end else begin
      pipe_good <= {pipe_good[LATENCY-4:0], 1'b1};
    end
  end

  // ****************************************************************
  // Output buffer
  // ****************************************************************
  acpd_stream_if #(.WIDTH(DATA_W)) fill_if ();
  acpd_stream_if #(.WIDTH(DATA_W)) drain_if ();

  assign fill_if.valid  = pipe_good[LATENCY-3] && active;
  assign fill_if.data   = pipe_word[LATENCY-3];
  assign drain_if.ready = drain_ready;

  acpd_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk     (clk),
    .reset_n (reset_n),
    .flush   (!active),
    .wr      (fill_if),
    .rd      (drain_if)
  );

  // Word lost when the drain side stalls
  always_ff @(posedge clk) begin
    if (!reset_n || !active) begin
      fifo_overflow <= 1'b0;
    end else if (fill_if.valid && !fill_if.ready) begin
      fifo_overflow <= 1'b1;
    end
  end

  // ****************************************************************
  // Data pins
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      data_out    <= acpd_pkg::RESET_WORD;
      word_strobe <= 1'b0;
    end else if (!active) begin
      data_out    <= acpd_pkg::UNDEF_WORD;
      word_strobe <= 1'b0;
    end else begin
      data_out    <= drain_if.data;
      word_strobe <= drain_if.valid && drain_ready;
    end
  end

  // Enable high floats all pins, low drives them
  assign data_oe    = oe_n_sync ? '0 : {DATA_W{1'b1}};
  assign data_valid = word_strobe && !oe_n_sync && active;
endmodule // acpd_core

// File: verif/acpd_properties.sv
// Checker for the converter control block.
// Assumes it is bound to acpd_core and sees only its ports.
`timescale 1ns/10ps
module acpd_properties (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        output_enable_n,
  input wire logic        sleep_request,
  input wire logic [11:0] data_out,
  input wire logic [11:0] data_oe,
  input wire logic        data_valid,
  input wire logic        word_strobe,
  input wire logic        sleeping,
  input wire logic        recovering
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ****************************************
  // Checks
  // ****************************************
  oe_drive_a: assert property (
    !output_enable_n [*4] |-> data_oe == 12'hFFF) else $error("pins idle");
  oe_float_a: assert property (
    output_enable_n [*4] |-> data_oe == 12'h000) else $error("pins driven");
  valid_driven_a: assert property (
    data_valid |-> data_oe == 12'hFFF) else $error("valid while undriven");
  valid_awake_a: assert property (
    sleeping || recovering |-> !data_valid) else $error("valid while idle");
  sleep_enter_a: assert property (
    sleep_request [*4] |-> sleeping) else $error("sleep not entered");
  sleep_quiet_a: assert property (
    sleeping && $past(sleeping) |-> !word_strobe) else $error("stale word");
  sleep_word_a: assert property (
    sleeping && $past(sleeping) && $past(reset_n)
    |-> data_out == acpd_pkg::UNDEF_WORD) else $error("sleep word wrong");
  recover_len_a: assert property (
    $rose(recovering) |-> recovering [*6] ##1 !recovering)
    else $error("recovery length wrong");
endmodule // acpd_properties

bind acpd_core acpd_properties acpd_properties_i (.clk, .reset_n,
  .output_enable_n, .sleep_request, .data_out, .data_oe, .data_valid,
  .word_strobe, .sleeping, .recovering);

// File: verif/acpd_capture.sv
// Capture logic model on the far side of the converter outputs.
// Assumes the same clock that the bench supplies to the converter.
`timescale 1ns/10ps
module acpd_capture (
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic [11:0] data_out,
  input  wire logic        data_valid,
  output logic             drain_ready,
  output logic      [11:0] word,
  output int               n_words,
  output int               n_gaps
);
  // Stall withholds acceptance of buffered words
  assign drain_ready = !stall;
  initial begin
    n_words = 0;
    n_gaps = 0;
    word = 12'h000;
  end
  // Register each valid word on the rising edge
  always @(posedge clk) begin
    if (data_valid) begin
      if (n_words > 0 && data_out !== word + 12'h001) n_gaps <= n_gaps + 1;
      word <= data_out;
      n_words <= n_words + 1;
    end
  end
endmodule // acpd_capture

// File: verif/acpd_core_tb.sv
// Self-checking bench of the converter control block.
// Assumes a free-running sample ramp and one capture model.
`timescale 1ns/10ps
module acpd_core_tb;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [11:0] sample_in = 12'h000;
  logic        output_enable_n = 1'b0;
  logic        sleep_request = 1'b0;
  logic        stall = 1'b0;
  logic        drain_ready;
  logic [11:0] data_out, data_oe, word;
  logic        data_valid, word_strobe, sleeping, recovering, fifo_overflow;
  int          n_words, n_gaps, n_errors = 0, compares = 0, n_strobe = 0;
  int          w, g, s;

  acpd_core acpd_core_i (.clk, .reset_n, .sample_in, .output_enable_n,
    .sleep_request, .drain_ready, .data_out, .data_oe, .data_valid,
    .word_strobe, .sleeping, .recovering, .fifo_overflow);
  acpd_capture acpd_capture_i (.clk, .stall, .data_out, .data_valid,
    .drain_ready, .word, .n_words, .n_gaps);

  initial forever #25 clk = ~clk;
  // One new sample every rising edge, as a ramp
  always @(posedge clk) sample_in <= sample_in + 12'h001;
  always @(posedge clk) n_strobe <= n_strobe + int'(word_strobe);

  // ****************************************
  // Helpers
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [11:0] exp,
                     input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_run;
    int i;
    for (i = 0; i < 60 && (sleeping !== 1'b0 || recovering !== 1'b0); i++)
      tick(1);
    chk("awake", 12'h000, {11'h000, sleeping | recovering});
    tick(acpd_pkg::LATENCY_CYCLES + 4);
  endtask
  task automatic test_done;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  task automatic t_stream;
    w = n_words;
    g = n_gaps;
    tick(20);
    chk("word count", 12'h014, 12'(n_words - w));
    chk("gaps", 12'h000, 12'(n_gaps - g));
    // Ramp leads by one, capture register lags by one
    chk("latency", 12'(acpd_pkg::LATENCY_CYCLES + 2),
        sample_in - word);
    $display("stream test done");
  endtask
  task automatic t_enable;
    @(posedge clk) output_enable_n <= 1'b1;
    tick(4);
    s = n_strobe;
    chk("oe high", 12'h000, data_oe);
    tick(10);
    chk("strobes", 12'h00A, 12'(n_strobe - s));
    chk("valid", 12'h000, {11'h000, data_valid});
    @(posedge clk) output_enable_n <= 1'b0;
    tick(4);
    chk("oe low", 12'hFFF, data_oe);
    $display("enable test done");
  endtask
  task automatic t_stall;
    @(posedge clk) stall <= 1'b1;
    tick(40);
    chk("overflow", 12'h001, {11'h000, fifo_overflow});
    @(posedge clk) stall <= 1'b0;
    $display("stall test done");
  endtask
  task automatic t_sleep;
    @(posedge clk) sleep_request <= 1'b1;
    tick(6);
    chk("sleeping", 12'h001, {11'h000, sleeping});
    chk("sleep word", acpd_pkg::UNDEF_WORD, data_out);
    chk("overflow", 12'h000, {11'h000, fifo_overflow});
    tick(20);
    @(posedge clk) sleep_request <= 1'b0;
    wait_run();
    chk("fresh", 12'(acpd_pkg::LATENCY_CYCLES + 2),
        sample_in - word);
    $display("sleep test done");
  endtask

  initial begin
    tick(4);
    @(posedge clk) reset_n <= 1'b1;
    wait_run();
    t_stream();
    t_enable();
    t_stall();
    t_sleep();
    t_stream();
    test_done();
  end
  initial begin
    #(2000 * 50);
    n_errors++;
    test_done();
  end
endmodule // acpd_core_tb
